// *** core/ctb_clock_timebase.sv ***
// Clock selection, stop and wait control, power-on counters and time base.
// Assumes oscillator levels and wake pins arrive asynchronously and are
// sampled here; CPU strobes and interrupt summary come from clk_in logic.
module ctb_clock_timebase
    import ctb_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      resetn_in,
    input  wire logic                      por_in,
    input  wire logic                      main_oscillator_in,
    input  wire logic                      sub_oscillator_in,
    input  wire logic                      ext_irq_in,
    input  wire logic                      key_wakeup_interrupt_in,
    input  wire logic                      spi_slave_in,
    input  wire logic                      any_irq_in,
    input  wire logic                      stop_req_in,
    input  wire logic                      wait_req_in,
    input  wire logic [ctb_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [7:0]                wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output logic [7:0]                     rdata_out,
    output logic                           main_osc_run_out,
    output logic                           system_bus_clock_out,
    output logic                           cpu_clk_en_out,
    output logic                           lcd_clock_out,
    output logic                           timebase_irq_out,
    output logic                           watchdog_tick_out,
    output logic                           por_reset_out,
    output logic                           option_map_select_out,
    output logic                           stopped_out
);
    import ctb_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [5:0]  meta_ff;
    logic [5:0]  sync_ff;
    logic [1:0]  osc_d_ff;

    // Two stages for each oscillator, power-on and wake pin, a third stage for oscillator edges.
    always_ff @(posedge clk_in) begin
        meta_ff  <= {main_oscillator_in, sub_oscillator_in, por_in,
                     ext_irq_in, key_wakeup_interrupt_in, spi_slave_in};
        sync_ff  <= meta_ff;
        osc_d_ff <= sync_ff[5:4];
    end

    // ************************************************************
    // Registers and state
    // ************************************************************
    logic        por;
    logic        rst;
    logic [1:0]  sel_ff;
    logic [1:0]  sel_act_ff;
    logic        men_ff;
    logic        option_map_select_ff;
    logic        tsrc_ff;
    logic        lcds_ff;
    logic        timebase_irq_enable_ff;
    logic [1:0]  rate_ff;
    logic        timebase_irq_flag_ff;
    logic        mrdy_ff;
    logic        srdy_ff;
    logic        por_act_ff;
    logic [12:0] div_ff;
    logic [13:0] tb_ff;
    logic        sub_half_ff;
    ctb_pwr_e    pwr_ff;
    logic [7:0]  nxt_rdata;
    logic        main_run;
    logic        main_edge;
    logic        sub_edge;
    logic        main_ovf;
    logic        stop_entry;
    logic        tb_tick;
    logic        tb_wrap;
    logic        tbi_hit;
    logic        irq_req;
    logic        wake_stop;
    logic        src_pulse;
    logic        cpu_hold;
    logic        wr_misc;
    logic        wr_tb2;

    // Power-on detection dominates; system reset leaves counters and ready flags alone.
    assign por        = sync_ff[3];
    assign rst        = ~resetn_in | por;
    assign wr_misc    = wr_in & (addr_in == MISC_OFS);
    assign wr_tb2     = wr_in & (addr_in == TIMEBASE_CTRL_TWO_OFS);
    assign stop_entry = stop_req_in & (pwr_ff == PWR_RUN);

    // Main oscillator runs only while enabled and not stopped.
    assign main_run  = men_ff & (pwr_ff != PWR_STOP);
    assign main_edge = sync_ff[5] & ~osc_d_ff[1] & main_run;
    assign sub_edge  = sync_ff[4] & ~osc_d_ff[0];
    assign main_ovf  = main_edge & (&div_ff);

    // ************************************************************
    // Register writes
    // ************************************************************
    // Main control register fields.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            sel_ff  <= SEL_RST;
            men_ff  <= MEN_RST;
            option_map_select_ff <= OPTION_MAP_SELECT_RST;
        end else if (wr_misc) begin
            sel_ff  <= {wdata_in[SEL_HI_B], wdata_in[SEL_LO_B]};
            men_ff  <= wdata_in[MEN_B];
            option_map_select_ff <= wdata_in[OPTION_MAP_SELECT_B];
        end
    end

    // Time base control fields.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            tsrc_ff <= TSRC_RST;
            lcds_ff <= LCDS_RST;
            timebase_irq_enable_ff <= TIMEBASE_IRQ_ENABLE_RST;
            rate_ff <= RATE_RST;
        end else begin
            if (wr_in && addr_in == TIMEBASE_CTRL_ONE_OFS) begin
                tsrc_ff <= wdata_in[TSRC_B];
                lcds_ff <= wdata_in[LCDS_B];
            end
            if (wr_tb2) begin
                timebase_irq_enable_ff <= wdata_in[TIMEBASE_IRQ_ENABLE_B];
                rate_ff <= {wdata_in[RATE_HI_B], wdata_in[RATE_LO_B]};
            end
        end
    end

    // ************************************************************
    // Main divider and power-on counter
    // ************************************************************
    // Low seven bits divide the main clock, high six bits count to overflow.
    always_ff @(posedge clk_in) begin
        if (por || !men_ff) begin
            div_ff <= MAIN_PRESET;
        end else if (stop_entry) begin
            div_ff[12:7] <= '0;
        end else if (main_edge) begin
            div_ff <= 13'(div_ff + 13'h0001);
        end
    end

    // Main ready flag; overflow wins over a simultaneous clear.
    always_ff @(posedge clk_in) begin
        if (por) begin
            mrdy_ff <= 1'b0;
        end else if (main_ovf) begin
            mrdy_ff <= 1'b1;
        end else if (!men_ff || stop_entry) begin
            mrdy_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Time base
    // ************************************************************
    // The main source enters through the divide-by-128 carry.
    assign tb_tick = tsrc_ff ? (main_edge & (&div_ff[6:0])) : sub_edge;

    // Period end for the selected interrupt rate.
    always_comb begin
        tb_wrap = 1'b0;
        unique case (rate_ff)
            2'b00: tb_wrap = &tb_ff[6:0];
            2'b01: tb_wrap = &tb_ff[11:0];
            2'b10: tb_wrap = &tb_ff[12:0];
            2'b11: tb_wrap = &tb_ff;
        endcase
    end
    assign tbi_hit = tb_tick & tb_wrap;
    assign irq_req = timebase_irq_flag_ff & timebase_irq_enable_ff;

    // Counter keeps running in stop on the sub source; only power-on presets it.
    always_ff @(posedge clk_in) begin
        if (por) begin
            tb_ff <= TB_PRESET;
        end else if (tb_tick) begin
            tb_ff <= 14'(tb_ff + 14'h0001);
        end
    end

    // Sub ready flag is sticky until power is removed.
    always_ff @(posedge clk_in) begin
        if (por) begin
            srdy_ff <= 1'b0;
        end else if (tb_tick && (&tb_ff)) begin
            srdy_ff <= 1'b1;
        end
    end

    // Interrupt flag; writing one to its bit clears it, a new period wins.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            timebase_irq_flag_ff <= 1'b0;
        end else if (tbi_hit) begin
            timebase_irq_flag_ff <= 1'b1;
        end else if (wr_tb2 && wdata_in[TIMEBASE_IRQ_FLAG_B]) begin
            timebase_irq_flag_ff <= 1'b0;
        end
    end

    // Derived time base outputs.
    always_ff @(posedge clk_in) begin
        if (por) begin
            lcd_clock_out     <= 1'b0;
            timebase_irq_out  <= 1'b0;
            watchdog_tick_out <= 1'b0;
        end else begin
            lcd_clock_out     <= lcds_ff ? tb_ff[6] : tb_ff[5];
            timebase_irq_out  <= irq_req;
            watchdog_tick_out <= tbi_hit;
        end
    end

    // ************************************************************
    // Power-on release
    // ************************************************************
    // Held until both oscillators have counted through their start time.
    always_ff @(posedge clk_in) begin
        if (por) begin
            por_act_ff <= 1'b1;
        end else if (srdy_ff && mrdy_ff) begin
            por_act_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Stop and wait control
    // ************************************************************
    assign wake_stop = |sync_ff[2:0] | irq_req;

    // Run, wait and stop states; reset always returns to run.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            pwr_ff <= PWR_RUN;
        end else begin
            unique case (pwr_ff)
                PWR_RUN: begin
                    if (stop_req_in) begin
                        pwr_ff <= PWR_STOP;
                    end else if (wait_req_in) begin
                        pwr_ff <= PWR_WAIT;
                    end
                end
                PWR_WAIT: begin
                    if (any_irq_in || wake_stop) begin
                        pwr_ff <= PWR_RUN;
                    end
                end
                PWR_STOP: begin
                    if (wake_stop) begin
                        pwr_ff <= PWR_RUN;
                    end
                end
                default: pwr_ff <= PWR_RUN;
            endcase
        end
    end

    // ************************************************************
    // System clock generation
    // ************************************************************
    // Sub clock halved for the slow system clock choice.
    always_ff @(posedge clk_in) begin
        if (por) begin
            sub_half_ff <= 1'b0;
        end else if (sub_edge) begin
            sub_half_ff <= ~sub_half_ff;
        end
    end

    // One enable pulse per period of the active division.
    always_comb begin
        src_pulse = 1'b0;
        unique case (sel_act_ff)
            SEL_MAIN_D2:  src_pulse = main_edge & div_ff[0];
            SEL_MAIN_D4:  src_pulse = main_edge & (&div_ff[1:0]);
            SEL_MAIN_D64: src_pulse = main_edge & (&div_ff[5:0]);
            SEL_SUB_D2:   src_pulse = sub_edge & sub_half_ff;
        endcase
    end

    // A new selection is taken only at a pulse, so no period is cut short.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            sel_act_ff <= SEL_RST;
        end else if (src_pulse || sel_act_ff == sel_ff) begin
            sel_act_ff <= sel_ff;
        end
    end

    // CPU waits for the main ready flag whenever main drives the system.
    assign cpu_hold = (sel_act_ff != SEL_SUB_D2) & ~mrdy_ff;

    // Clock enables and status pins.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            system_bus_clock_out <= 1'b0;
            cpu_clk_en_out       <= 1'b0;
            main_osc_run_out     <= 1'b0;
            stopped_out          <= 1'b0;
        end else begin
            system_bus_clock_out <= src_pulse & (pwr_ff != PWR_STOP);
            cpu_clk_en_out       <= src_pulse & (pwr_ff == PWR_RUN) & ~cpu_hold;
            main_osc_run_out     <= main_run;
            stopped_out          <= (pwr_ff == PWR_STOP);
        end
    end

    assign por_reset_out         = por_act_ff;
    assign option_map_select_out = option_map_select_ff;

    // ************************************************************
    // Register read
    // ************************************************************
    // Unmapped addresses and reserved bits read as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (addr_in == MISC_OFS) begin
            nxt_rdata[MRDY_B]   = mrdy_ff;
            nxt_rdata[SRDY_B]   = srdy_ff;
            nxt_rdata[SEL_HI_B] = sel_ff[1];
            nxt_rdata[SEL_LO_B] = sel_ff[0];
            nxt_rdata[MEN_B]    = men_ff;
            nxt_rdata[OPTION_MAP_SELECT_B]   = option_map_select_ff;
        end else if (addr_in == TIMEBASE_CTRL_ONE_OFS) begin
            nxt_rdata[TSRC_B] = tsrc_ff;
            nxt_rdata[LCDS_B] = lcds_ff;
        end else if (addr_in == TIMEBASE_CTRL_TWO_OFS) begin
            nxt_rdata[TIMEBASE_IRQ_FLAG_B]    = timebase_irq_flag_ff;
            nxt_rdata[TIMEBASE_IRQ_ENABLE_B]    = timebase_irq_enable_ff;
            nxt_rdata[RATE_HI_B] = rate_ff[1];
            nxt_rdata[RATE_LO_B] = rate_ff[0];
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_in) begin
        if (rst || !rd_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= nxt_rdata;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst);

    stop_clears_a: assert property (stop_entry && !main_ovf && men_ff |=>
        !mrdy_ff && div_ff[12:7] == 6'h00)
        else $error("stop entry did not clear ready and counter");
    stop_halts_a: assert property (pwr_ff == PWR_STOP |=>
        !main_osc_run_out && !system_bus_clock_out && !cpu_clk_en_out)
        else $error("clocks running in stop");
    stop_wake_a: assert property (pwr_ff == PWR_STOP && sync_ff[2] |=>
        pwr_ff == PWR_RUN)
        else $error("external irq did not end stop");
    recov_hold_a: assert property (cpu_hold |=> !cpu_clk_en_out)
        else $error("CPU clocked before main ready");
    sub_resume_a: assert property (pwr_ff == PWR_STOP && wake_stop && men_ff
        |=> ##1 main_osc_run_out)
        else $error("main did not restart after stop");
    wait_periph_a: assert property (pwr_ff == PWR_WAIT && src_pulse |=>
        system_bus_clock_out && !cpu_clk_en_out)
        else $error("wait clocks wrong");
    ovf_ready_a: assert property (main_ovf |=> mrdy_ff)
        else $error("overflow did not set main ready");
    men_clear_a: assert property (!men_ff |=>
        div_ff == MAIN_PRESET && !mrdy_ff && !main_osc_run_out)
        else $error("disable did not preset main counters");
    sub_sticky_a: assert property (srdy_ff |=> srdy_ff)
        else $error("sub ready flag dropped");
    rsvd_zero_a: assert property (rd_in && addr_in == MISC_OFS |=>
        rdata_out[5:4] == 2'b00 && rdata_out[MEN_B] == $past(men_ff))
        else $error("control register read wrong");
    tbi_set_a: assert property (tbi_hit |=>
        timebase_irq_flag_ff ##1 (timebase_irq_out == $past(timebase_irq_enable_ff)))
        else $error("time base flag or request wrong");
    sel_switch_a: assert property ($changed(sel_act_ff) |->
        $past(src_pulse) || $past(rst))
        else $error("clock select switched mid period");

    stop_exit_c: cover property (pwr_ff == PWR_STOP ##1 pwr_ff == PWR_RUN);
    wait_exit_c: cover property (pwr_ff == PWR_WAIT ##1 pwr_ff == PWR_RUN);
    sub_sel_c:   cover property ($rose(sel_act_ff == SEL_SUB_D2));
    tbi_req_c:   cover property ($rose(timebase_irq_out));

endmodule : ctb_clock_timebase

// *** core/ctb_pkg.sv ***
// Constants, field positions and state codes of the clock and time base block.
// Assumes a single 20 MHz clock and a plain strobe register port around the block.
//
// Function
// - Stop halts main oscillator and sub clock path; only the time base runs, on the sub source.
// - Entering stop clears main ready flag and clears the power-on counter; a main overflow in the same cycle sets ready instead.
// - Stop exits on reset, external irq, key wakeup, serial slave or time base irq.
// - Main source in stop: CPU resumes after power-on counter overflow, which sets ready.
// - Sub source in stop: resume at once; main restarts only if enabled.
// - Wait halts only CPU clocks; reset or any interrupt exits it.
// - Sub divider preset to 0078 at power-on; overflow sets sub ready, releases power-on; release also waits for main ready.
// - Oscillator divided by two feeds system clock; by 64 or 128 feeds LCD.
// - Main ready clears on power-on or enable clear; set by overflow; reset ignores it.
// - Sub ready clears on power-on, sets after 16264 clocks, then stays; reset ignores.
// - Control register bits five and four read as zero.
// - Select 00 main/2 default, 01 main/4, 10 main/64, 11 sub/2.
// - Setting main enable restarts main; ready sets 8072 clocks later on overflow.
// - Clearing main enable stops main, presets divider and counter, clears ready.
// - Reset sets main enable; software keeps it set while main clocks the system.
// - Option map select chooses register map, 1 option, 0 main; cleared on reset.
// - Time base is a 14-bit up-counter preset to 0078 only at power-on.
// - Time base input selects main or sub; outputs feed LCD, ready, irq, watchdog.
// - LCD clock is time base clock divided by 64 or 128.
// - Time base flag sets every period; irq requested only while enabled.
// - Rate field selects time base clock divided by 128, 4096, 8192 or 16384.
// - Power-on counter is 6 bits, clocked by main divided by 128.
package ctb_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned MDIV_W          = 7;
    localparam int unsigned PCNT_W          = 6;
    localparam int unsigned TB_W            = 14;
    localparam int unsigned MAIN_READY_CLKS = 8072;
    localparam int unsigned SUB_READY_CLKS  = 16264;
    localparam logic [12:0] MAIN_PRESET     = 13'((2 ** 13) - MAIN_READY_CLKS);
    localparam logic [13:0] TB_PRESET       = 14'((2 ** 14) - SUB_READY_CLKS);

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] MISC_OFS  = 8'h0C;
    localparam logic [7:0] TIMEBASE_CTRL_ONE_OFS = 8'h10;
    localparam logic [7:0] TIMEBASE_CTRL_TWO_OFS = 8'h11;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned MRDY_B  = 7;
    localparam int unsigned SRDY_B  = 6;
    localparam int unsigned SEL_HI_B = 3;
    localparam int unsigned SEL_LO_B = 2;
    localparam int unsigned MEN_B   = 1;
    localparam int unsigned OPTION_MAP_SELECT_B  = 0;
    localparam int unsigned TSRC_B  = 1;
    localparam int unsigned LCDS_B  = 0;
    localparam int unsigned TIMEBASE_IRQ_FLAG_B  = 7;
    localparam int unsigned TIMEBASE_IRQ_ENABLE_B  = 6;
    localparam int unsigned RATE_HI_B = 1;
    localparam int unsigned RATE_LO_B = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] SEL_RST  = 2'h0;
    localparam logic       MEN_RST  = 1'b1;
    localparam logic       OPTION_MAP_SELECT_RST = 1'b0;
    localparam logic       TSRC_RST = 1'b0;
    localparam logic       LCDS_RST = 1'b0;
    localparam logic       TIMEBASE_IRQ_ENABLE_RST = 1'b0;
    localparam logic [1:0] RATE_RST = 2'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SEL_MAIN_D2  = 2'b00,
        SEL_MAIN_D4  = 2'b01,
        SEL_MAIN_D64 = 2'b10,
        SEL_SUB_D2   = 2'b11
    } ctb_sel_e;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_STOP = 2'b10
    } ctb_pwr_e;

endpackage : ctb_pkg

// *** testbench/ctb_osc_model.sv ***
// Oscillator model: main square wave gated by run_in, free-running sub oscillator square wave.
// Assumes clk_in at 20 MHz; each level lasts HALF clk_in cycles.
module ctb_osc_model #(
    parameter int HALF = 2
) (
    input  wire logic clk_in,
    input  wire logic run_in,
    output logic      main_osc_out,
    output logic      sub_osc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial main_osc_out = 1'b0;
    initial sub_osc_out = 1'b0;
    // A stopped crystal freezes its level; the sub oscillator never stops.
    always @(posedge clk_in) begin
        cnt <= (cnt + 1) % HALF;
        if (cnt == HALF - 1) begin
            sub_osc_out <= ~sub_osc_out;
            if (run_in === 1'b1) main_osc_out <= ~main_osc_out;
        end
    end
endmodule : ctb_osc_model

// *** testbench/test_clock_and_timebase_control.sv ***
// Self-checking bench for the clock and time base block.
// Assumes the oscillator model and register offsets of ctb_pkg.
module test_clock_and_timebase_control;
    import ctb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, resetn_in = 0, por_in = 1, wr_in = 0, rd_in = 0;
    logic ext_in = 0, key_in = 0, spi_in = 0, any_in = 0, stop_in = 0, wait_in = 0;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, rv;
    logic mosc, sosc, mrun, sbc, cpu_en, irq, porr, option_map_select, stp, lcd, wdt;
    int n_fail = 0, num_checks = 0, cyc = 0, k, c, b;
    ctb_clock_timebase i_ctb_clock_timebase (.clk_in(clk_in), .resetn_in(resetn_in),
        .por_in(por_in), .main_oscillator_in(mosc), .sub_oscillator_in(sosc),
        .ext_irq_in(ext_in), .key_wakeup_interrupt_in(key_in), .spi_slave_in(spi_in),
        .any_irq_in(any_in), .stop_req_in(stop_in), .wait_req_in(wait_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .main_osc_run_out(mrun), .system_bus_clock_out(sbc),
        .cpu_clk_en_out(cpu_en), .lcd_clock_out(lcd), .timebase_irq_out(irq),
        .watchdog_tick_out(wdt), .por_reset_out(porr), .option_map_select_out(option_map_select),
        .stopped_out(stp));
    ctb_osc_model i_ctb_osc_model (.clk_in(clk_in), .run_in(mrun),
        .main_osc_out(mosc), .sub_osc_out(sosc));
    // Clock at 50 ns period.
    always #25 clk_in = ~clk_in;
    // Compares one value and counts the outcome.
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Register write and read, each entered just after a rising edge.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        rd_in <= 1'b1; addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
        @(posedge clk_in);
    endtask : rd
    // Counts cpu clock enables and system bus clock enables over 40 cycles.
    task automatic cpu_pulses(output int n, output int m);
        n = 0;
        m = 0;
        repeat (40) begin
            @(posedge clk_in);
            #1 n += int'(cpu_en === 1'b1);
            m += int'(sbc === 1'b1);
        end
    endtask : cpu_pulses
    // Counts cycles between two rises of the watchdog tick or the LCD clock.
    task automatic rise_gap(input bit use_lcd, output int n);
        logic prev, cur;
        int i, seen;
        prev = 1'b1;
        seen = 0;
        n = 0;
        for (i = 0; i < 3000 && seen < 2; i++) begin
            @(posedge clk_in);
            #1 cur = use_lcd ? lcd : wdt;
            if (cur === 1'b1 && prev !== 1'b1) seen++;
            if (seen == 1) n++;
            prev = cur;
        end
    endtask : rise_gap
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // Cuts a hang short well above the expected run length.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 95000) begin
            n_fail++;
            results();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1; por_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        check("por_reset", {7'h0, porr}, 8'h01);
        rd(MISC_OFS, rv);
        check("misc_por", rv, 8'h02);
        for (k = 0; k < 40000 && rv[7:6] !== 2'b11; k++) rd(MISC_OFS, rv);
        check("por_release", {7'h0, porr}, 8'h00);
        resetn_in <= 1'b0;
        @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        rd(MISC_OFS, rv);
        check("misc_reset", rv, 8'hC2);
        rd(8'h3F, rv);
        check("unmapped", rv, 8'h00);
        wr(MISC_OFS, 8'h0E);
        rd(MISC_OFS, rv);
        check("misc_sub", rv, 8'hCE);
        for (k = 0; k < 3; k++) begin
            stop_in <= 1'b1;
            @(posedge clk_in);
            stop_in <= 1'b0;
            repeat (2) @(posedge clk_in);
            #1 check("stop", {6'h0, stp, mrun}, 8'h02);
            {spi_in, key_in, ext_in} <= 3'b001 << k;
            for (c = 0; c < 8 && stp !== 1'b0; c++) @(posedge clk_in);
            check("wake", {7'h0, stp}, 8'h00);
            {spi_in, key_in, ext_in} <= 3'b000;
            rd(MISC_OFS, rv);
            check("misc_stop", rv, 8'h4E);
        end
        wait_in <= 1'b1;
        @(posedge clk_in);
        wait_in <= 1'b0;
        cpu_pulses(c, b);
        check("wait_cpu", 8'(c), 8'h00);
        check("wait_bus", {7'h0, b > 0}, 8'h01);
        any_in <= 1'b1;
        @(posedge clk_in);
        any_in <= 1'b0;
        cpu_pulses(c, b);
        check("wait_exit", {7'h0, c > 0}, 8'h01);
        // One time base tick is four clk_in cycles with the oscillator model's default.
        rise_gap(1'b0, c);
        check("tb_period", 8'(c / 4), 8'd128);
        check("tb_phase", 8'(c % 4), 8'h00);
        wr(TIMEBASE_CTRL_TWO_OFS, 8'h40);
        for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge clk_in);
        check("tb_irq", {7'h0, irq}, 8'h01);
        rd(TIMEBASE_CTRL_TWO_OFS, rv);
        check("timebase_ctrl_two", rv, 8'hC0);
        wr(TIMEBASE_CTRL_TWO_OFS, 8'hC0);
        repeat (3) @(posedge clk_in);
        #1 check("tb_clear", {7'h0, irq}, 8'h00);
        for (k = 0; k < 600 && irq !== 1'b1; k++) @(posedge clk_in);
        check("tb_again", {7'h0, irq}, 8'h01);
        rise_gap(1'b1, c);
        check("lcd_fast", 8'(c / 4), 8'd64);
        wr(TIMEBASE_CTRL_ONE_OFS, 8'h01);
        rd(TIMEBASE_CTRL_ONE_OFS, rv);
        check("timebase_ctrl_one", rv, 8'h01);
        rise_gap(1'b1, c);
        check("lcd_slow", 8'(c / 4), 8'd128);
        wr(MISC_OFS, 8'h3D);
        rd(MISC_OFS, rv);
        check("misc_off", rv, 8'h4D);
        check("opt_run", {6'h0, option_map_select, mrun}, 8'h02);
        results();
    end
endmodule : test_clock_and_timebase_control
